/* File: hw/gsu_defines.svh */
// Purpose: Shared constants of the guarded store unit
// Assumes: Included by bare name from the lane steering and store unit files
// Notes:   Definitions only
`ifndef GSU_DEFINES_SVH
`define GSU_DEFINES_SVH

// Byte lane swap values for word stores
`define GSU_SWAP_LITTLE    2'h3
`define GSU_SWAP_BIG       2'h0
// Fixed delivery for the I/O aperture, byte order ignored
`define GSU_SWAP_MMIO      2'h3
// Low address bits of an aligned word
`define GSU_WORD_ALIGNED   2'h0
// Displacement used by the plain forms
`define GSU_DISP_ZERO      9'h000
// No byte lane written
`define GSU_BE_NONE        4'h0
// All four lanes written
`define GSU_BE_ALL         4'hf
// Single low lane, shifted to the byte position
`define GSU_BE_LOW         4'h1
// Default I/O aperture size, a plain choice
`define GSU_MMIO_SIZE_DFLT 32'h0020_0000

`endif

/* File: hw/gsu_pkg.sv */
// Purpose: Types of the guarded store unit
// Assumes: Nothing beyond the defines header
// Notes:   Operation codes are one-hot
`default_nettype none
package gsu_pkg;

  // Store operation selector from the issue stage
  typedef enum logic [3:0]
  {
    GSU_OP_WORD_DISP = 4'h1,
    GSU_OP_WORD      = 4'h2,
    GSU_OP_BYTE_DISP = 4'h4,
    GSU_OP_BYTE      = 4'h8
  } gsu_op_t;

endpackage
`default_nettype wire

/* File: hw/gsu_lane_steer.sv */
// Purpose: Steers source bytes onto memory byte lanes
// Assumes: Lane j of the memory word holds the byte at address base + j
// Notes:   Purely combinational; the caller registers the results
`timescale 1ns/100ps
`default_nettype none
`include "gsu_defines.svh"

module gsu_lane_steer
(
  input  wire logic [31:0] value,      // Source operand
  input  wire logic [1:0]  lane_swap,  // Swap value for word stores
  input  wire logic [1:0]  byte_lane,  // Target lane of a byte store
  input  wire logic        is_byte,    // Byte store rather than word
  output logic      [31:0] lane_data,  // Steered data
  output logic      [3:0]  lane_be     // Byte enables
);

  // One steering slice per memory lane
  genvar j;
  generate
    for (j = 0; j < 4; j++)
    begin : g_lane
      logic [1:0] src_k;  // Source byte landing on this lane

      assign src_k = 2'h3 - (2'(j) ^ lane_swap);

      // byte store uses low byte only
      assign lane_data[8*j +: 8] = is_byte ? value[7:0]
                                           : value[{src_k, 3'h0} +: 8];
      assign lane_be[j] = is_byte ? (byte_lane == 2'(j)) : 1'b1;
    end
  endgenerate

endmodule
`default_nettype wire

/* File: hw/gsu_store_unit.sv */
// Purpose: Guarded store datapath between issue stage and data memory
// Assumes: Issue stage and memory system run on clk, no synchronisers
// Notes:   Misaligned word stores write nothing; the flag reports them
//
// Operation
// - Word store writes four bytes at base+disp
// - Word byte k lands at (3-k) xor swap
// - Misaligned word store sets the sticky flag
// - Trap enabled: request exception at interruptible jump
// - Aperture word stores ignore byte order
// - Guard bit zero suppresses every side effect
// - Cacheable store also updates cache copy
// - Byte store writes only low source byte
// - Byte store address is base plus displacement
// - Plain byte store uses zero displacement
// - Plain word store uses zero displacement
`timescale 1ns/100ps
`default_nettype none
`include "gsu_defines.svh"

module gsu_store_unit
#(
  parameter logic [31:0] MMIO_SIZE = `GSU_MMIO_SIZE_DFLT  // Aperture bytes
)
(
  input  wire logic            clk,                    // Processor clock
  input  wire logic            arst_n,                 // Async reset
  input  wire logic            issue_valid,            // Store offered
  output logic                 issue_ready,            // Store accepted
  input  wire gsu_pkg::gsu_op_t issue_op,              // Store kind
  input  wire logic [31:0]     base_operand,           // Address source
  input  wire logic [31:0]     value_operand,          // Data source
  input  wire logic [31:0]     guard_operand,          // Guard, bit 0
  input  wire logic [8:0]      disp,                   // Signed modifier
  input  wire logic            byte_order_flag,        // 1 little endian
  input  wire logic            misaligned_store_trap_enable, // Trap on
  input  wire logic            misaligned_store_flag_clear,  // SW clear
  input  wire logic            interruptible_jump,     // Jump point
  input  wire logic [31:0]     mmio_base,              // Aperture start
  output logic                 mem_valid,              // Write request
  input  wire logic            mem_ready,              // Memory takes it
  output logic      [31:0]     mem_addr,               // Word address
  output logic      [3:0]      mem_byte_en,            // Lane enables
  output logic      [31:0]     mem_data,               // Lane data
  output logic                 mem_mmio,               // Aperture access
  output logic                 mem_cache_update,       // Update cache copy
  output logic                 misaligned_store_flag,  // Sticky status
  output logic                 exception_request       // One-cycle pulse
);
  import gsu_pkg::*;

  // Decoded operation
  logic        take;        // Store accepted this cycle
  logic        is_word;     // Word form
  logic        is_byte;     // Byte form
  logic        bad_op;      // Illegal operation code
  logic [8:0]  disp_eff;    // Displacement after plain-form forcing
  logic [31:0] ea;          // Effective byte address
  logic [31:0] ap_off;      // Offset into the I/O aperture
  logic        in_mmio;     // Address hits the aperture
  logic        misalign;    // Enabled word store not word aligned
  logic        do_store;    // Request goes to memory
  logic [1:0]  lane_swap;   // Swap value in use
  logic [31:0] steer_data;  // Steered data from lane module
  logic [3:0]  steer_be;    // Steered enables from lane module

  // Memory request registers
  logic        mem_valid_q, mem_valid_d;
  logic [31:0] mem_addr_q, mem_addr_d;
  logic [3:0]  mem_be_q, mem_be_d;
  logic [31:0] mem_data_q, mem_data_d;
  logic        mem_mmio_q, mem_mmio_d;

  // Status registers
  logic        flag_q, flag_d;    // Misaligned store flag
  logic        pend_q, pend_d;    // Trap waiting for a jump
  logic        exc_q, exc_d;      // Exception request pulse

  // A slot is free when empty or being drained this cycle
  assign issue_ready = !mem_valid_q || mem_ready;
  assign take        = issue_valid && issue_ready;

  // Decode and address formation
  always_comb
  begin
    is_word  = 1'b0;
    is_byte  = 1'b0;
    bad_op   = 1'b0;
    disp_eff = disp;
    unique case (issue_op)
      GSU_OP_WORD_DISP:
      begin
        is_word = 1'b1;
      end
      GSU_OP_WORD:
      begin
        is_word  = 1'b1;
        disp_eff = `GSU_DISP_ZERO;
      end
      GSU_OP_BYTE_DISP:
      begin
        is_byte = 1'b1;
      end
      GSU_OP_BYTE:
      begin
        is_byte  = 1'b1;
        disp_eff = `GSU_DISP_ZERO;
      end
      // Unknown codes are dropped without effect
      default: bad_op = 1'b1;
    endcase
    ea      = base_operand + {{23{disp_eff[8]}}, disp_eff};
    ap_off  = ea - mmio_base;
    in_mmio = ap_off < MMIO_SIZE;
    // aperture ignores the byte order flag
    if (in_mmio)
      lane_swap = `GSU_SWAP_MMIO;
    else if (byte_order_flag)
      lane_swap = `GSU_SWAP_LITTLE;
    else
      lane_swap = `GSU_SWAP_BIG;
    // guard bit zero blocks all effects
    // word store needs a word aligned address
    misalign = take && guard_operand[0] && is_word && !bad_op
               && (ea[1:0] != `GSU_WORD_ALIGNED);
    do_store = take && guard_operand[0] && !bad_op && !misalign;
  end

  // Lane steering for both store widths
  gsu_lane_steer u_steer
  (
    .value     (value_operand),
    .lane_swap (lane_swap),
    .byte_lane (ea[1:0]),
    .is_byte   (is_byte),
    .lane_data (steer_data),
    .lane_be   (steer_be)
  );

  // Next request; held until the memory accepts it
  always_comb
  begin
    mem_valid_d = mem_valid_q && !mem_ready;
    mem_addr_d  = mem_addr_q;
    mem_be_d    = mem_be_q;
    mem_data_d  = mem_data_q;
    mem_mmio_d  = mem_mmio_q;
    if (do_store)
    begin
      mem_valid_d = 1'b1;
      mem_addr_d  = {ea[31:2], `GSU_WORD_ALIGNED};
      mem_be_d    = steer_be;
      mem_data_d  = steer_data;
      mem_mmio_d  = in_mmio;
    end
  end

  // Request registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mem_valid_q <= 1'b0;
      mem_addr_q  <= 32'h0000_0000;
      mem_be_q    <= `GSU_BE_NONE;
      mem_data_q  <= 32'h0000_0000;
      mem_mmio_q  <= 1'b0;
    end
    else
    begin
      mem_valid_q <= mem_valid_d;
      mem_addr_q  <= mem_addr_d;
      mem_be_q    <= mem_be_d;
      mem_data_q  <= mem_data_d;
      mem_mmio_q  <= mem_mmio_d;
    end
  end

  // Status next values; a new event beats a same-cycle clear
  always_comb
  begin
    // set wins, cleared only by software
    flag_d = misalign || (flag_q && !misaligned_store_flag_clear);
    // pending trap waits for the next jump
    pend_d = (misalign && misaligned_store_trap_enable)
             || (pend_q && !interruptible_jump);
    exc_d  = pend_q && interruptible_jump;
  end

  // Status registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flag_q <= 1'b0;
      pend_q <= 1'b0;
      exc_q  <= 1'b0;
    end
    else
    begin
      flag_q <= flag_d;
      pend_q <= pend_d;
      exc_q  <= exc_d;
    end
  end

  // Outputs; cache copy skipped for the uncached aperture
  assign mem_valid             = mem_valid_q;
  assign mem_addr              = mem_addr_q;
  assign mem_byte_en           = mem_be_q;
  assign mem_data              = mem_data_q;
  assign mem_mmio              = mem_mmio_q;
  // cacheable stores also update the cache
  assign mem_cache_update      = mem_valid_q && !mem_mmio_q;
  assign misaligned_store_flag = flag_q;
  assign exception_request     = exc_q;

  // Checks on the outputs against their causes
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_guard_blocks: assert property (
    take && !guard_operand[0] |=> !mem_valid && $stable(flag_q))
    else $error("guarded-off store had an effect");

  a_misalign_flag: assert property (
    take && guard_operand[0] && is_word && !bad_op
    && (ea[1:0] != `GSU_WORD_ALIGNED) |=> flag_q && !mem_valid)
    else $error("misaligned word store not flagged");

  a_flag_sticky: assert property (
    flag_q && !misaligned_store_flag_clear |=> flag_q)
    else $error("misaligned flag dropped without clear");

  a_word_little: assert property (
    do_store && is_word && !in_mmio && byte_order_flag
    |=> mem_data == $past(value_operand) && mem_byte_en == `GSU_BE_ALL)
    else $error("little endian word lanes wrong");

  a_word_big: assert property (
    do_store && is_word && !in_mmio && !byte_order_flag
    |=> mem_data == {$past(value_operand[7:0]), $past(value_operand[15:8]),
      $past(value_operand[23:16]), $past(value_operand[31:24])})
    else $error("big endian word lanes wrong");

  a_mmio_order: assert property (
    do_store && is_word && in_mmio
    |=> mem_mmio && mem_data == $past(value_operand))
    else $error("aperture word depends on byte order");

  a_byte_lane: assert property (
    do_store && is_byte |=> mem_byte_en == (`GSU_BE_LOW << $past(ea[1:0]))
    && mem_data[{$past(ea[1:0]), 3'h0} +: 8] == $past(value_operand[7:0]))
    else $error("byte store lane wrong");

  a_plain_addr: assert property (
    do_store && (issue_op == GSU_OP_BYTE || issue_op == GSU_OP_WORD)
    |=> mem_addr == {$past(base_operand[31:2]), `GSU_WORD_ALIGNED})
    else $error("plain store address not base");

  a_trap_jump: assert property (
    misalign && misaligned_store_trap_enable && !pend_q
    ##1 !interruptible_jump [*2] ##1 interruptible_jump
    |=> exception_request ##1 !exception_request)
    else $error("trap not requested at jump");

  a_cache_copy: assert property (
    do_store |=> mem_cache_update == !$past(in_mmio))
    else $error("cache update wrong for target");

endmodule
`default_nettype wire

/* File: verif/gsu_mem_model.sv */
// Purpose: Memory side model for the guarded store unit
// Assumes: A write is taken on rising clk with valid and ready
// Notes:   Ready is the inverse of the stall input; holds are checked
`timescale 1ns/100ps
`default_nettype none

module gsu_mem_model
(
  input  wire logic        clk,
  input  wire logic        stall,
  input  wire logic        mem_valid,
  output logic             mem_ready,
  input  wire logic [31:0] mem_addr,
  input  wire logic [3:0]  mem_byte_en,
  input  wire logic [31:0] mem_data,
  input  wire logic        mem_mmio,
  input  wire logic        mem_cache_update,
  output logic      [31:0] last_addr,
  output logic      [3:0]  last_be,
  output logic      [31:0] last_data,
  output logic      [1:0]  last_flags,
  output int               wr_count,
  output int               hold_err
);
  logic [69:0] held_q;         // Request seen in the previous cycle
  logic        stalled_q = 1'b0;
  initial wr_count = 0;
  initial hold_err = 0;
  // A slow memory: stalls whenever the bench asks it to
  assign mem_ready = !stall;
  // Capture writes; a stalled request must not move
  always @(posedge clk)
  begin
    if (stalled_q && held_q !== {mem_valid, mem_addr, mem_byte_en,
                                 mem_data, mem_mmio})
      hold_err <= hold_err + 1;
    stalled_q <= mem_valid && !mem_ready;
    held_q <= {mem_valid, mem_addr, mem_byte_en, mem_data, mem_mmio};
    if (mem_valid && mem_ready)
    begin
      wr_count <= wr_count + 1;
      last_addr <= mem_addr;
      last_be <= mem_byte_en;
      last_data <= mem_data;
      last_flags <= {mem_mmio, mem_cache_update};
    end
  end
endmodule

`default_nettype wire

/* File: verif/testbench.sv */
// Purpose: Self-checking bench of the guarded store unit
// Assumes: Inputs change on the falling clock edge
// Notes:   Memory side is the gsu_mem_model partner
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import gsu_pkg::*;
  logic        clk = 1'b0, arst_n = 1'b0, issue_valid = 1'b0;
  logic        bo = 1'b0, trap_en = 1'b0, clr = 1'b0, jump = 1'b0;
  logic        stall = 1'b0, issue_ready, mem_valid, mem_ready;
  logic        mem_mmio, mem_cu, flag, exc;
  gsu_op_t     issue_op = GSU_OP_WORD;
  logic [31:0] base = 32'h0, value = 32'h0, guard = 32'h0;
  logic [31:0] mmio_base = 32'h4000_0000, mem_addr, mem_data;
  logic [31:0] last_addr, last_data;
  logic [8:0]  disp = 9'h000;
  logic [3:0]  mem_be, last_be;
  logic [1:0]  last_flags;
  int          wr_count, hold_err, err_count = 0, tests_run = 0, cyc = 0;

  gsu_store_unit dut (.clk(clk), .arst_n(arst_n),
    .issue_valid(issue_valid), .issue_ready(issue_ready),
    .issue_op(issue_op), .base_operand(base), .value_operand(value),
    .guard_operand(guard), .disp(disp), .byte_order_flag(bo),
    .misaligned_store_trap_enable(trap_en),
    .misaligned_store_flag_clear(clr), .interruptible_jump(jump),
    .mmio_base(mmio_base), .mem_valid(mem_valid), .mem_ready(mem_ready),
    .mem_addr(mem_addr), .mem_byte_en(mem_be), .mem_data(mem_data),
    .mem_mmio(mem_mmio), .mem_cache_update(mem_cu),
    .misaligned_store_flag(flag), .exception_request(exc));
  gsu_mem_model mem (.clk(clk), .stall(stall), .mem_valid(mem_valid),
    .mem_ready(mem_ready), .mem_addr(mem_addr), .mem_byte_en(mem_be),
    .mem_data(mem_data), .mem_mmio(mem_mmio), .mem_cache_update(mem_cu),
    .last_addr(last_addr), .last_be(last_be), .last_data(last_data),
    .last_flags(last_flags), .wr_count(wr_count), .hold_err(hold_err));

  // 50 MHz clock
  always #10 clk = ~clk;

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Hang guard: whole run needs well under 1000 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      close_out();
    end
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Offer one store and hold it until the edge that takes it
  task automatic issue(gsu_op_t op, logic [31:0] b, v, logic [8:0] d,
                       logic [31:0] g);
    @(negedge clk);
    issue_op = op;
    base = b;
    value = v;
    disp = d;
    guard = g;
    issue_valid = 1'b1;
    // Look just after the falling edge, so a stall change there is seen
    #1;
    while (issue_ready !== 1'b1)
    begin
      @(negedge clk);
      #1;
    end
    @(negedge clk);
    issue_valid = 1'b0;
  endtask

  // Guarded store that must reach memory with the given lanes
  task automatic wr(gsu_op_t op, logic [31:0] b, v, logic [8:0] d,
                    logic [31:0] a, logic [3:0] be, logic [31:0] dt,
                    logic mm);
    int n;
    n = wr_count;
    issue(op, b, v, d, 32'h1);
    repeat (2) @(negedge clk);
    check("count", wr_count, n + 1);
    check("addr", last_addr, a);
    check("be", {28'h0, last_be}, {28'h0, be});
    check("data", last_data, dt);
    check("mmio,cache", {30'h0, last_flags}, {30'h0, mm, !mm});
  endtask

  // Store that must leave memory untouched
  task automatic nowr(gsu_op_t op, logic [31:0] b, logic [8:0] d,
                      logic [31:0] g);
    int n;
    n = wr_count;
    issue(op, b, 32'h5555_aaaa, d, g);
    repeat (2) @(negedge clk);
    check("no write", wr_count, n);
  endtask

  task automatic t_word;
    bo = 1'b0;
    wr(GSU_OP_WORD_DISP, 32'hcfc, 32'h4433_2211, 9'h004, 32'hd00, 4'hf,
       32'h1122_3344, 1'b0);
    bo = 1'b1;
    wr(GSU_OP_WORD_DISP, 32'hd0c, 32'haabb_ccdd, 9'h1f8, 32'hd04, 4'hf,
       32'haabb_ccdd, 1'b0);
    wr(GSU_OP_WORD_DISP, 32'h1100, 32'h1234_5678, 9'h100, 32'h1000, 4'hf,
       32'h1234_5678, 1'b0);
    wr(GSU_OP_WORD_DISP, 32'h1000, 32'h1, 9'h0fc, 32'h10fc, 4'hf,
       32'h1, 1'b0);
    wr(GSU_OP_WORD, 32'h2000, 32'h8765_4321, 9'h010, 32'h2000, 4'hf,
       32'h8765_4321, 1'b0);
    $display("word stores done");
  endtask

  task automatic t_byte;
    for (int i = 0; i < 2; i++)
    begin
      bo = i[0];
      wr(GSU_OP_BYTE_DISP, 32'hd00, 32'h4433_2211, 9'h003, 32'hd00, 4'h8,
         32'h1111_1111, 1'b0);
      wr(GSU_OP_BYTE_DISP, 32'hd02, 32'haabb_ccdd, 9'h1fc, 32'hcfc, 4'h4,
         32'hdddd_dddd, 1'b0);
    end
    wr(GSU_OP_BYTE_DISP, 32'h3040, 32'h5a, 9'h1c0, 32'h3000, 4'h1,
       32'h5a5a_5a5a, 1'b0);
    wr(GSU_OP_BYTE_DISP, 32'h3000, 32'h7e, 9'h03f, 32'h303c, 4'h8,
       32'h7e7e_7e7e, 1'b0);
    wr(GSU_OP_BYTE, 32'hd02, 32'haabb_ccdd, 9'h005, 32'hd00, 4'h4,
       32'hdddd_dddd, 1'b0);
    $display("byte stores done");
  endtask

  // Only word stores go to the aperture, keeping issuer duty
  // no byte stores here
  task automatic t_mmio;
    bo = 1'b0;
    wr(GSU_OP_WORD_DISP, 32'h4000_0010, 32'h4433_2211, 9'h004,
       32'h4000_0014, 4'hf, 32'h4433_2211, 1'b1);
    wr(GSU_OP_WORD, 32'h401f_fffc, 32'h4433_2211, 9'h000,
       32'h401f_fffc, 4'hf, 32'h4433_2211, 1'b1);
    wr(GSU_OP_WORD, 32'h4020_0000, 32'h4433_2211, 9'h000,
       32'h4020_0000, 4'hf, 32'h1122_3344, 1'b0);
    $display("aperture stores done");
  endtask

  task automatic t_guard_flag;
    trap_en = 1'b1;
    nowr(GSU_OP_WORD_DISP, 32'hd0b, 9'h1f8, 32'hffff_fffe);
    nowr(GSU_OP_BYTE, 32'hd00, 9'h000, 32'h0);
    // Undefined operation code: taken, no write and no flag
    nowr(gsu_op_t'(4'h3), 32'hd01, 9'h004, 32'h1);
    check("flag", {31'h0, flag}, 32'h0);
    trap_en = 1'b0;
    nowr(GSU_OP_WORD_DISP, 32'hd01, 9'h004, 32'h1);
    check("flag", {31'h0, flag}, 32'h1);
    wr(GSU_OP_WORD, 32'hd00, 32'h1, 9'h000, 32'hd00, 4'hf, 32'h0100_0000,
       1'b0);
    check("flag", {31'h0, flag}, 32'h1);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    @(negedge clk);
    check("flag", {31'h0, flag}, 32'h0);
    trap_en = 1'b1;
    nowr(GSU_OP_WORD, 32'hd02, 9'h000, 32'h1);
    check("exception", {31'h0, exc}, 32'h0);
    jump = 1'b1;
    @(negedge clk);
    jump = 1'b0;
    check("exception", {31'h0, exc}, 32'h1);
    @(negedge clk);
    check("exception", {31'h0, exc}, 32'h0);
    $display("guard and status done");
  endtask

  task automatic t_stall;
    int n;
    n = wr_count;
    stall = 1'b1;
    issue(GSU_OP_WORD, 32'h5000, 32'h1, 9'h000, 32'h1);
    check("issue_ready", {31'h0, issue_ready}, 32'h0);
    fork
      issue(GSU_OP_WORD, 32'h5004, 32'h2, 9'h000, 32'h1);
      begin
        repeat (3) @(negedge clk);
        stall = 1'b0;
      end
    join
    repeat (2) @(negedge clk);
    check("count", wr_count, n + 2);
    check("addr", last_addr, 32'h5004);
    check("hold", hold_err, 32'h0);
    $display("stall done");
  endtask

  initial
  begin
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    t_word();
    t_byte();
    t_mmio();
    t_guard_flag();
    t_stall();
    close_out();
  end
endmodule

`default_nettype wire
